// file: core/cuc_top.sv
// Chip unsecure control: key unlock, options byte rewrite and blank check gating
`timescale 1ns/100ps
module cuc_top
  import cuc_pkg::*;
#(
  parameter int KEY_WORDS = CUC_KEY_WORDS
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic normal_single_chip_mode_i,
  input wire logic normal_expanded_mode_i,
  input wire logic special_single_chip_mode_i,
  input wire logic all_nvm_blank_i,
  input wire logic sector_protected_i,
  input wire logic key_wr_i,
  input wire logic [CUC_KEY_IDX_W-1:0] key_wr_idx_i,
  input wire logic [15:0] key_wr_data_i,
  input wire logic key_prog_i,
  input wire logic [CUC_KEY_IDX_W-1:0] key_prog_idx_i,
  input wire logic [15:0] key_prog_data_i,
  input wire logic opt_erase_i,
  input wire logic opt_prog_i,
  input wire logic [7:0] opt_prog_data_i,
  input wire logic bdm_cmd_i,
  output logic secured_o,
  output logic [1:0] security_state_field_o,
  output logic [1:0] key_unlock_enable_o,
  output logic key_unlocked_o,
  output logic key_fail_o,
  output logic opt_cmd_done_o,
  output logic opt_cmd_refused_o,
  output logic bdm_blocked_o,
  output logic bdm_hw_only_o,
  output logic bdm_all_cmds_o,
  output logic ready_o
);
  initial begin
    if (KEY_WORDS != CUC_KEY_WORDS) $error("cuc_top: KEY_WORDS must be %0d", CUC_KEY_WORDS);
    // Key buffer slicing and the sector index both rely on a power-of-two word count
    if ((1 << CUC_KEY_IDX_W) != KEY_WORDS) begin
      $error("cuc_top: key index width does not match KEY_WORDS");
    end
    if (CUC_SEC_RESET == CUC_SEC_UNSECURED) begin
      $error("cuc_top: reset security code must be a secured code");
    end
  end

  // Effective security: latched field, lifted by key unlock or a passed blank check
  function automatic logic eff_secured(input logic [1:0] sec, input logic unlocked,
    input logic all_cmds);
    return ~cuc_unsecured(sec) & ~unlocked & ~all_cmds;
  endfunction : eff_secured

  // A word of all zeros or all ones never unlocks, even if both sides agree
  function automatic logic key_word_pass(input logic [15:0] stored,
    input logic [15:0] supplied);
    return stored == supplied && stored != CUC_WORD_ZERO && stored != CUC_WORD_ONES;
  endfunction : key_word_pass

  typedef struct packed {
    cuc_state_t st;
    logic load_wait;
    logic [1:0] sec;
    logic [1:0] keyen;
    logic key_unlocked;
    logic key_fail;
    logic [CUC_KEY_WORDS-1:0] key_ok;
    logic [CUC_KEY_WORDS*16-1:0] key_buf;
    logic [CUC_KEY_IDX_W-1:0] idx;
    logic cmp_ok;
    logic done;
    logic refused;
    logic blocked;
    logic hw_only;
    logic all_cmds;
    logic ready;
    logic secured;
  } cuc_regs_t;

  // Reset image: secured, debug port blocked, copy from the options byte still to come
  localparam cuc_regs_t REGS_RESET = '{
    st: CUC_ST_LOAD,
    load_wait: 1'b0,
    sec: CUC_SEC_RESET,
    keyen: CUC_KEYEN_RESET,
    key_unlocked: 1'b0,
    key_fail: 1'b0,
    key_ok: '0,
    key_buf: '0,
    idx: '0,
    cmp_ok: 1'b0,
    done: 1'b0,
    refused: 1'b0,
    blocked: 1'b1,
    hw_only: 1'b0,
    all_cmds: 1'b0,
    ready: 1'b0,
    secured: 1'b1
  };

  cuc_regs_t q_r;
  cuc_regs_t q_nxt;

  logic [15:0] key_rdata;
  logic [7:0] opt_rdata;
  logic erase;
  logic key_we;
  logic opt_we;
  logic [CUC_KEY_IDX_W-1:0] rd_idx;
  logic normal_mode;
  logic sec_now;
  logic opt_allowed;
  logic [15:0] sup_word;
  logic word_pass;
  logic last_word;
  logic cmd_req;
  logic key_gate;
  logic start_cmp;

  assign normal_mode = normal_single_chip_mode_i | normal_expanded_mode_i;
  assign sec_now = eff_secured(q_r.sec, q_r.key_unlocked, q_r.all_cmds);
  assign sup_word = q_r.key_buf[16*q_r.idx +: 16];
  assign word_pass = key_word_pass(key_rdata, sup_word);
  assign last_word = q_r.idx == CUC_KEY_IDX_W'(CUC_KEY_WORDS - 1);
  assign cmd_req = opt_erase_i | opt_prog_i | key_prog_i;
  // Key unlock exists only in normal modes and only with the enable code latched
  assign key_gate = normal_mode && q_r.keyen == CUC_KEYEN_ENABLED;
  assign start_cmp = &q_r.key_ok && !key_wr_i;

  // Options sector commands: from firmware in normal single chip, once unsecured from any mode, special single chip needing all_cmds
  always_comb begin
    opt_allowed = q_r.ready & ~sector_protected_i;
    if (sec_now) begin
      opt_allowed = opt_allowed & normal_single_chip_mode_i;
    end else if (special_single_chip_mode_i) begin
      opt_allowed = opt_allowed & q_r.all_cmds;
    end
    opt_allowed = opt_allowed & (normal_single_chip_mode_i | q_r.key_unlocked
                                 | q_r.all_cmds | ~sec_now);
  end

  assign erase = opt_erase_i & opt_allowed;
  assign opt_we = opt_prog_i & opt_allowed & ~opt_erase_i;
  assign key_we = key_prog_i & opt_allowed & ~opt_erase_i;
  assign rd_idx = (q_r.st == CUC_ST_KEYCMP) ? q_r.idx : '0;

  // Sector commands share one permission; erase wins when both strobes arrive together
  cuc_nvm_sector #(
    .WORDS(CUC_KEY_WORDS)
  ) u_sector (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .erase_i(erase),
    .key_we_i(key_we),
    .key_idx_i(key_prog_idx_i),
    .key_wdata_i(key_prog_data_i),
    .opt_we_i(opt_we),
    .opt_wdata_i(opt_prog_data_i),
    .rd_idx_i(rd_idx),
    .key_rdata_o(key_rdata),
    .opt_rdata_o(opt_rdata)
  );

  always_comb begin
    q_nxt = q_r;
    q_nxt.done = 1'b0;
    q_nxt.refused = 1'b0;
    q_nxt.key_fail = 1'b0;
    if (key_wr_i) begin
      q_nxt.key_buf[16*key_wr_idx_i +: 16] = key_wr_data_i;
      q_nxt.key_ok[key_wr_idx_i] = 1'b1;
    end
    // Every command strobe seen while ready gets exactly one answer pulse, accepted or refused
    if (q_r.ready && cmd_req) begin
      q_nxt.done = opt_allowed;
      q_nxt.refused = ~opt_allowed;
    end
    case (q_r.st)
      CUC_ST_LOAD: begin
        // Sector read data is registered and its register comes out of reset erased,
        // so the copy waits one cycle for the stored byte to reach the read port
        q_nxt.key_unlocked = 1'b0;
        q_nxt.all_cmds = 1'b0;
        q_nxt.hw_only = 1'b0;
        if (!q_r.load_wait) begin
          q_nxt.load_wait = 1'b1;
        end else begin
          q_nxt.sec = opt_rdata[1:0];
          q_nxt.keyen = opt_rdata[7:6];
          if (special_single_chip_mode_i && !cuc_unsecured(opt_rdata[1:0])) begin
            q_nxt.st = CUC_ST_BLANK;
            q_nxt.blocked = 1'b1;
          end else begin
            q_nxt.st = CUC_ST_RUN;
            q_nxt.blocked = 1'b0;
            q_nxt.all_cmds = special_single_chip_mode_i;
            q_nxt.ready = 1'b1;
          end
        end
      end
      CUC_ST_BLANK: begin
        // One sampled cycle of the blank result; a slower check would stay here longer
        q_nxt.blocked = 1'b0;
        q_nxt.all_cmds = all_nvm_blank_i;
        q_nxt.hw_only = ~all_nvm_blank_i;
        q_nxt.ready = 1'b1;
        q_nxt.st = CUC_ST_RUN;
      end
      CUC_ST_RUN: begin
        // Key attempt starts once all four words are written; a word written during the
        // compare lands mid-attempt, so firmware must wait for the verdict first
        if (start_cmp) begin
          q_nxt.key_ok = '0;
          q_nxt.idx = '0;
          q_nxt.cmp_ok = 1'b1;
          q_nxt.st = CUC_ST_KEYCMP;
        end
      end
      CUC_ST_KEYCMP: begin
        // Sector read lags index by a cycle; HOLD compares each word once its read data arrives
        q_nxt.st = CUC_ST_HOLD;
      end
      CUC_ST_HOLD: begin
        if (!word_pass) begin
          q_nxt.cmp_ok = 1'b0;
        end
        if (last_word) begin
          q_nxt.st = CUC_ST_RUN;
          if (q_r.cmp_ok && word_pass && key_gate) begin
            q_nxt.key_unlocked = 1'b1;
          end else begin
            q_nxt.key_fail = 1'b1;
          end
        end else begin
          q_nxt.idx = q_r.idx + 1'b1;
          q_nxt.st = CUC_ST_KEYCMP;
        end
      end
      default: begin
        // Unused codes fall back to a fresh load of the options byte
        q_nxt.st = CUC_ST_LOAD;
      end
    endcase
    // Reprogrammed options byte is not re-copied here; it waits for reset
    q_nxt.secured = eff_secured(q_nxt.sec, q_nxt.key_unlocked, q_nxt.all_cmds);
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      q_r <= REGS_RESET;
    end else begin
      q_r <= q_nxt;
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      secured_o <= 1'b1;
      security_state_field_o <= CUC_SEC_RESET;
      key_unlock_enable_o <= CUC_KEYEN_RESET;
      key_unlocked_o <= 1'b0;
      key_fail_o <= 1'b0;
      opt_cmd_done_o <= 1'b0;
      opt_cmd_refused_o <= 1'b0;
      bdm_blocked_o <= 1'b1;
      bdm_hw_only_o <= 1'b0;
      bdm_all_cmds_o <= 1'b0;
      ready_o <= 1'b0;
    end else begin
      secured_o <= q_nxt.secured;
      security_state_field_o <= q_nxt.sec;
      key_unlock_enable_o <= q_nxt.keyen;
      key_unlocked_o <= q_nxt.key_unlocked;
      key_fail_o <= q_nxt.key_fail;
      opt_cmd_done_o <= q_nxt.done;
      opt_cmd_refused_o <= q_nxt.refused;
      bdm_blocked_o <= q_nxt.blocked | (bdm_cmd_i & q_nxt.blocked);
      bdm_hw_only_o <= q_nxt.hw_only;
      bdm_all_cmds_o <= q_nxt.all_cmds | (~q_nxt.secured & ~q_nxt.blocked);
      ready_o <= q_nxt.ready;
    end
  end
endmodule : cuc_top

// file: core/cuc_pkg.sv
// Package for the chip unsecure control block: encodings, sizes and reset values
package cuc_pkg;
  localparam int CUC_KEY_WORDS = 4;
  localparam int CUC_KEY_IDX_W = 2;
  localparam logic [1:0] CUC_SEC_UNSECURED = 2'h2;
  localparam logic [1:0] CUC_KEYEN_ENABLED = 2'h2;
  localparam logic [1:0] CUC_SEC_RESET = 2'h1;
  localparam logic [1:0] CUC_KEYEN_RESET = 2'h0;
  localparam logic [15:0] CUC_WORD_ZERO = 16'h0000;
  localparam logic [15:0] CUC_WORD_ONES = 16'hFFFF;
  localparam logic [7:0] CUC_OPT_ERASED = 8'hFF;
  localparam logic [15:0] CUC_KEY_ERASED = 16'hFFFF;

  typedef enum logic [2:0] {
    CUC_ST_LOAD = 3'b000,
    CUC_ST_BLANK = 3'b001,
    CUC_ST_RUN = 3'b010,
    CUC_ST_KEYCMP = 3'b011,
    CUC_ST_HOLD = 3'b100
  } cuc_state_t;

  function automatic logic cuc_unsecured(input logic [1:0] f);
    return f == CUC_SEC_UNSECURED;
  endfunction : cuc_unsecured
endpackage : cuc_pkg

// file: core/cuc_nvm_sector.sv
// Options sector store: key words and options byte, registered read port
`timescale 1ns/100ps
module cuc_nvm_sector
  import cuc_pkg::*;
#(
  parameter int WORDS = CUC_KEY_WORDS
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic erase_i,
  input wire logic key_we_i,
  input wire logic [CUC_KEY_IDX_W-1:0] key_idx_i,
  input wire logic [15:0] key_wdata_i,
  input wire logic opt_we_i,
  input wire logic [7:0] opt_wdata_i,
  input wire logic [CUC_KEY_IDX_W-1:0] rd_idx_i,
  output logic [15:0] key_rdata_o,
  output logic [7:0] opt_rdata_o
);
  logic [15:0] mem [WORDS];
  logic [7:0] opt;

  initial begin
    if (WORDS != (1 << CUC_KEY_IDX_W)) $error("cuc_nvm_sector: WORDS must match index width");
  end

  // Reset only loads the read registers; array contents are kept, as real cells are nonvolatile
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      key_rdata_o <= CUC_KEY_ERASED;
      opt_rdata_o <= CUC_OPT_ERASED;
    end else begin
      key_rdata_o <= mem[rd_idx_i];
      opt_rdata_o <= opt;
    end
  end

  always_ff @(posedge clock_i) begin
    if (erase_i) begin
      for (int i = 0; i < WORDS; i++) begin
        mem[i] <= CUC_KEY_ERASED;
      end
      opt <= CUC_OPT_ERASED;
    end else begin
      if (key_we_i) begin
        mem[key_idx_i] <= key_wdata_i;
      end
      if (opt_we_i) begin
        opt <= opt & opt_wdata_i;
      end
    end
  end
endmodule : cuc_nvm_sector

// file: dv/cuc_top_asserts.sv
// Checker: port-level timing relations of the unsecure control block
`timescale 1ns/100ps
module cuc_top_asserts
  import cuc_pkg::*;
#(
  parameter int KEY_WORDS = CUC_KEY_WORDS
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic normal_single_chip_mode_i,
  input wire logic normal_expanded_mode_i,
  input wire logic sector_protected_i,
  input wire logic key_prog_i,
  input wire logic opt_erase_i,
  input wire logic opt_prog_i,
  input wire logic secured_o,
  input wire logic [1:0] security_state_field_o,
  input wire logic [1:0] key_unlock_enable_o,
  input wire logic key_unlocked_o,
  input wire logic key_fail_o,
  input wire logic opt_cmd_done_o,
  input wire logic opt_cmd_refused_o,
  input wire logic bdm_blocked_o,
  input wire logic bdm_hw_only_o,
  input wire logic bdm_all_cmds_o,
  input wire logic ready_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  property p_unsec_code;
    ready_o && security_state_field_o == CUC_SEC_UNSECURED |-> !secured_o;
  endproperty
  a_unsec_code: assert property (p_unsec_code) else $error("unsecured code but secured");
  property p_unlock_keep;
    key_unlocked_o |=> key_unlocked_o;
  endproperty
  a_unlock_keep: assert property (p_unlock_keep) else $error("unlock dropped");
  property p_unlock_cause;
    $rose(key_unlocked_o) |-> key_unlock_enable_o == CUC_KEYEN_ENABLED && !secured_o
      && (normal_single_chip_mode_i || normal_expanded_mode_i);
  endproperty
  a_unlock_cause: assert property (p_unlock_cause) else $error("bad unlock");
  property p_fail_pulse;
    key_fail_o |-> !key_unlocked_o ##1 !key_fail_o;
  endproperty
  a_fail_pulse: assert property (p_fail_pulse) else $error("key fail misbehaves");
  property p_protect;
    ready_o && sector_protected_i && (opt_erase_i || opt_prog_i || key_prog_i)
      |=> opt_cmd_refused_o && !opt_cmd_done_o;
  endproperty
  a_protect: assert property (p_protect) else $error("protected command taken");
  property p_ns_ok;
    ready_o && normal_single_chip_mode_i && !sector_protected_i && (opt_erase_i || opt_prog_i)
      |=> opt_cmd_done_o;
  endproperty
  a_ns_ok: assert property (p_ns_ok) else $error("options command not done");
  property p_hw_only;
    bdm_hw_only_o |-> secured_o && !bdm_all_cmds_o && !bdm_blocked_o;
  endproperty
  a_hw_only: assert property (p_hw_only) else $error("debug gating wrong");
  property p_blocked;
    bdm_blocked_o |-> !bdm_hw_only_o && !bdm_all_cmds_o;
  endproperty
  a_blocked: assert property (p_blocked) else $error("debug open while blocked");
  cover property (key_unlocked_o);
  cover property (opt_cmd_refused_o);
  cover property (bdm_all_cmds_o);
endmodule : cuc_top_asserts
bind cuc_top cuc_top_asserts #(.KEY_WORDS(KEY_WORDS)) cuc_top_asserts_i (.*);

// file: dv/cuc_fw_model.sv
// Firmware model: supplies the four key words of an unlock attempt
`timescale 1ns/100ps
module cuc_fw_model (
  input wire logic clock_i,
  input wire logic go_i,
  input wire logic bad_i,
  output logic key_wr_o,
  output logic [1:0] idx_o,
  output logic [15:0] data_o
);
  logic [2:0] left_r = 3'h0;
  logic [15:0] word;
  // Never all zeros or all ones; bad_i spoils the last word only
  assign word = (16'hA5A0 + {14'h0000, idx_o}) ^ {15'h0000, bad_i && idx_o == 2'h3};
  assign key_wr_o = left_r != 3'h0;
  assign idx_o = 2'(3'h4 - left_r);
  // Inverse between frames so stale data never looks valid
  assign data_o = key_wr_o ? word : ~word;
  always_ff @(posedge clock_i) begin
    if (left_r == 3'h0 && go_i) begin
      left_r <= 3'h4;
    end else if (left_r != 3'h0) begin
      left_r <= left_r - 3'h1;
    end
  end
endmodule : cuc_fw_model

// file: dv/chip_unsecure_control_test.sv
// Testbench for the chip unsecure control block
`timescale 1ns/100ps
module chip_unsecure_control_test;
  import cuc_pkg::*;
  typedef struct packed {logic e; logic p; logic pr; logic [7:0] d; logic ok;} cuc_row_t;
  logic clock_i = 1'h0, reset_i = 1'h1, normal_single_chip_mode_i = 1'h1;
  logic normal_expanded_mode_i = 1'h0, special_single_chip_mode_i = 1'h0, go = 1'h0;
  logic all_nvm_blank_i = 1'h0, sector_protected_i = 1'h0, key_prog_i = 1'h0, bad = 1'h0;
  logic opt_erase_i = 1'h0, opt_prog_i = 1'h0, bdm_cmd_i = 1'h0;
  logic [1:0] key_prog_idx_i = 2'h0, key_wr_idx_i, security_state_field_o, key_unlock_enable_o;
  logic [15:0] key_prog_data_i = 16'h0000, key_wr_data_i;
  logic [7:0] opt_prog_data_i = 8'h00;
  logic key_wr_i, secured_o, key_unlocked_o, key_fail_o, opt_cmd_done_o, opt_cmd_refused_o;
  logic bdm_blocked_o, bdm_hw_only_o, bdm_all_cmds_o, ready_o;
  int error_cnt = 0;
  int checked = 0;
  cuc_row_t rows [4] = '{'{1'h1, 1'h0, 1'h0, 8'hFF, 1'h1}, '{1'h0, 1'h1, 1'h1, 8'hBD, 1'h0},
    '{1'h0, 1'h1, 1'h0, 8'hBD, 1'h1}, '{1'h1, 1'h0, 1'h1, 8'hFF, 1'h0}};
  cuc_top cuc_top_i (.*);
  cuc_fw_model cuc_fw_model_i (.clock_i, .go_i(go), .bad_i(bad), .key_wr_o(key_wr_i),
    .idx_o(key_wr_idx_i), .data_o(key_wr_data_i));
  always #25 clock_i = ~clock_i;
  task automatic chk(input logic [1:0] seen, input logic [1:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %b expected %b", $time, seen, exp);
    end
  endtask : chk
  task automatic results;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results
  task automatic rst;
    reset_i = 1'h1;
    repeat (16) @(negedge clock_i);
    reset_i = 1'h0;
    for (int i = 0; i < 8 && ready_o !== 1'h1; i++) @(negedge clock_i);
    chk({ready_o, bdm_blocked_o}, 2'h2);
  endtask : rst
  task automatic cmd(input logic e, input logic p, input logic k, input logic [7:0] d,
    input logic ok);
    opt_erase_i = e;
    opt_prog_i = p;
    key_prog_i = k;
    opt_prog_data_i = d;
    @(negedge clock_i);
    // Answer pulse stands for the one cycle after the taking edge
    chk({opt_cmd_done_o, opt_cmd_refused_o}, {ok, !ok});
    opt_erase_i = 1'h0;
    opt_prog_i = 1'h0;
    key_prog_i = 1'h0;
    @(negedge clock_i);
  endtask : cmd
  task automatic keyt(input logic b, input logic [1:0] x);
    bad = b;
    go = 1'h1;
    @(negedge clock_i);
    go = 1'h0;
    for (int i = 0; i < 40 && key_unlocked_o !== 1'h1 && key_fail_o !== 1'h1; i++)
      @(negedge clock_i);
    chk({key_unlocked_o, key_fail_o}, x);
  endtask : keyt
  // Whole run is a few hundred cycles; this leaves ample margin
  initial begin
    #(4000 * 50);
    error_cnt++;
    results();
  end
  initial begin
    rst();
    foreach (rows[i]) begin
      sector_protected_i = rows[i].pr;
      cmd(rows[i].e, rows[i].p, 1'h0, rows[i].d, rows[i].ok);
    end
    sector_protected_i = 1'h0;
    for (int i = 0; i < 4; i++) begin
      key_prog_idx_i = 2'(i);
      key_prog_data_i = 16'hA5A0 + 16'(i);
      cmd(1'h0, 1'h0, 1'h1, 8'h00, 1'h1);
    end
    rst();
    chk(security_state_field_o, 2'h1);
    chk(key_unlock_enable_o, CUC_KEYEN_ENABLED);
    keyt(1'h1, 2'h1);
    chk({secured_o, key_unlocked_o}, 2'h2);
    keyt(1'h0, 2'h2);
    chk({secured_o, key_unlocked_o}, 2'h1);
    rst();
    chk({secured_o, key_unlocked_o}, 2'h2);
    normal_single_chip_mode_i = 1'h0;
    normal_expanded_mode_i = 1'h1;
    cmd(1'h0, 1'h1, 1'h0, 8'hBE, 1'h0);
    keyt(1'h0, 2'h2);
    cmd(1'h0, 1'h1, 1'h0, 8'hFF, 1'h1);
    normal_single_chip_mode_i = 1'h1;
    normal_expanded_mode_i = 1'h0;
    rst();
    cmd(1'h1, 1'h0, 1'h0, 8'hFF, 1'h1);
    keyt(1'h0, 2'h1);
    cmd(1'h0, 1'h1, 1'h0, 8'hBE, 1'h1);
    chk({secured_o, key_unlocked_o}, 2'h2);
    rst();
    chk(security_state_field_o, 2'h2);
    chk({secured_o, 1'h0}, 2'h0);
    cmd(1'h1, 1'h0, 1'h0, 8'hFF, 1'h1);
    normal_single_chip_mode_i = 1'h0;
    special_single_chip_mode_i = 1'h1;
    bdm_cmd_i = 1'h1;
    rst();
    chk({bdm_hw_only_o, bdm_all_cmds_o}, 2'h2);
    cmd(1'h0, 1'h1, 1'h0, 8'hBE, 1'h0);
    // Host has mass erased every array
    all_nvm_blank_i = 1'h1;
    rst();
    chk({bdm_hw_only_o, bdm_all_cmds_o}, 2'h1);
    cmd(1'h0, 1'h1, 1'h0, 8'hBE, 1'h1);
    rst();
    chk(security_state_field_o, 2'h2);
    results();
  end
endmodule : chip_unsecure_control_test
